// ===== dv/host_serial_model.sv
// Host side of the serial command link: sends frames of up to 24 bits.
// Assumes the decoder samples data on the rising serial clock edge.
`timescale 1ns/1ps
module host_serial_model (
  // Serial pins toward the decoder.
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_data
);
  // Idle: deselected, serial clock parked low between frames.
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data = 1'b0;
  end

  // Sends the low n bits of d, most significant first, 125 ns per bit.
  task automatic send_word(input logic [23:0] d, input int n);
    int i;
    chip_select_n = 1'b0;
    #40;
    for (i = n - 1; i >= 0; i--) begin
      serial_data = d[i];
      #62.5 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
    end
    #40 chip_select_n = 1'b1;
    // Released data shows the inverse, so a stale bit never looks valid.
    serial_data = ~serial_data;
    #200;
  endtask
endmodule

// ===== dv/rx_config_command_decoder_tb.sv
// Self-checking bench for the receiver configuration command decoder.
// Assumes the host model drives the serial pins and the package constants.
`timescale 1ns/1ps
module rx_config_command_decoder_tb;
  typedef struct packed {
    logic [15:0] cfg, freq, rx, wake, oword;
    logic [7:0] ocnt, scnt;
  } note_t;
  logic clk, arst_n, cs_n, sclk, sdata, ssf, qdo, crl;
  logic [15:0] cfg_w, freq_w, rx_w, wake_w, oword, oword_seen;
  logic [1:0] band, c1;
  logic [8:0] bw;
  logic [5:0] cap, c2;
  logic lbd, wt, sck, cko, tail, vdo, chain, ovalid, srp;
  logic [11:0] frac;
  logic [4:0] lna, wexp;
  logic [6:0] thr;
  logic [7:0] wmant, ocnt_seen, scnt_seen;
  logic [31:0] rnd;
  int seed = 32'h822391c6;
  int fails = 0;
  int num_checks = 0;
  int i;
  note_t m;
  note_t notes[$];

  rx_config_command_decoder rx_config_command_decoder_inst (.clk(clk),
    .arst_n(arst_n), .chip_select_n(cs_n), .serial_clk(sclk),
    .serial_data(sdata), .signal_strength_flag(ssf),
    .quality_detect_out(qdo), .clock_recovery_lock(crl),
    .rf_config_word(cfg_w), .synth_frequency_word(freq_w),
    .receiver_setting_word(rx_w), .wake_period_word(wake_w),
    .band_sel(band), .baseband_bw_khz(bw), .crystal_load_half_pf(cap),
    .low_batt_detect_on(lbd), .wake_timer_on(wt),
    .sleep_crystal_keep(sck), .clock_output_off(cko),
    .clock_tail_enable(tail), .synth_c1(c1), .synth_c2(c2),
    .synth_frac(frac), .valid_data_out(vdo), .lna_atten_db(lna),
    .rssi_thr_neg_dbm(thr), .receiver_chain_on(chain),
    .wake_exponent(wexp), .wake_mantissa(wmant), .other_cmd_word(oword),
    .other_cmd_valid(ovalid), .soft_reset_pulse(srp));
  host_serial_model host_serial_model_inst (.chip_select_n(cs_n),
    .serial_clk(sclk), .serial_data(sdata));

  always #5 clk = ~clk;

  // Pulses are counted so a missing or doubled pulse shows at the compare.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ocnt_seen <= 8'h00;
      scnt_seen <= 8'h00;
    end else begin
      if (ovalid === 1'b1) ocnt_seen <= ocnt_seen + 8'h01;
      if (ovalid === 1'b1) oword_seen <= oword;
      if (srp === 1'b1) scnt_seen <= scnt_seen + 8'h01;
    end
  end

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // Decoded fields are worked out from the expected words; tail is expected low, valid is left to vdi_check.
  task automatic verify(input note_t e);
    logic [8:0] bwt [8];
    logic [1:0] c1t [4];
    logic [5:0] c2t [4];
    logic [4:0] att [4];
    logic [6:0] t;
    bwt = '{9'h0, 9'h190, 9'h154, 9'h10e, 9'h0c8, 9'h086, 9'h043, 9'h0};
    c1t = '{2'h1, 2'h1, 2'h2, 2'h3};
    c2t = '{6'h1f, 6'h2b, 6'h2b, 6'h1e};
    att = '{5'h00, 5'h0e, 5'h06, 5'h14};
    t = 7'h67 - 7'h06 * {4'h0, e.rx[3:1]} + 7'(att[e.rx[5:4]]);
    check("cfg", cfg_w, e.cfg);
    check("freq", freq_w, e.freq);
    check("rx", rx_w, e.rx);
    check("wake", wake_w, e.wake);
    check("band", 16'(band), 16'(e.cfg[12:11]));
    check("bw", 16'(bw), 16'(bwt[e.cfg[3:1]]));
    check("cap", 16'(cap), 16'(6'h11 + e.cfg[7:4]));
    check("lbd", 16'(lbd), 16'(e.cfg[10]));
    check("wt", 16'(wt), 16'(e.cfg[9]));
    check("xtal", 16'(sck), 16'(e.cfg[8]));
    check("cko", 16'(cko), 16'(e.cfg[0]));
    check("tail", 16'(tail), 16'h0000);
    check("c1", 16'(c1), 16'(c1t[e.cfg[12:11]]));
    check("c2", 16'(c2), 16'(c2t[e.cfg[12:11]]));
    check("frac", 16'(frac), 16'(e.freq[11:0]));
    check("lna", 16'(lna), 16'(att[e.rx[5:4]]));
    if (e.rx[3:1] <= 3'h5) check("thr", 16'(thr), 16'(t));
    check("chain", 16'(chain), 16'(e.rx[0]));
    check("exp", 16'(wexp), 16'(e.wake[12:8]));
    check("mant", 16'(wmant), 16'(e.wake[7:0]));
    check("other", 16'(ocnt_seen), 16'(e.ocnt));
    if (e.ocnt != 8'h00) check("oword", oword_seen, e.oword);
    check("soft", 16'(scnt_seen), 16'(e.scnt));
  endtask

  // Only whole 16-bit frames change the expected state.
  task automatic send(input logic [23:0] d, input int n);
    logic [15:0] w;
    w = d[15:0];
    if (n == 16) begin
      if (w == 16'hff00) begin
        m.cfg = rx_cmd_pkg::CFG_RESET;
        m.freq = rx_cmd_pkg::FREQ_RESET;
        m.rx = rx_cmd_pkg::RX_RESET;
        m.wake = rx_cmd_pkg::WAKE_RESET;
        m.scnt = m.scnt + 8'h01;
      end else if (w[15:13] == 3'h4) m.cfg = w;
      else if (w[15:12] == 4'ha) begin
        if (w[11:0] >= 12'h060 && w[11:0] <= 12'hf3f) m.freq = w;
      end else if (w[15:8] == 8'hc0) m.rx = w;
      else if (w[15:13] == 3'h7) m.wake = w;
      else begin
        m.ocnt = m.ocnt + 8'h01;
        m.oword = w;
      end
    end
    notes.push_back(m);
    host_serial_model_inst.send_word(d, n);
  endtask

  // Valid output follows the flag picked by receiver bits 7:6.
  task automatic vdi_check;
    logic [2:0] f;
    logic v;
    repeat (3) begin
      @(posedge clk);
      f = 3'($random(seed));
      ssf <= f[0];
      qdo <= f[1];
      crl <= f[2];
      @(posedge clk);
      #1;
      case (m.rx[7:6])
        2'h0: v = f[0];
        2'h1: v = f[1];
        2'h2: v = f[2];
        default: v = f[0] & f[1];
      endcase
      check("valid", 16'(vdo), 16'(v));
    end
  endtask

  // Compare each frame's result once the commit has settled.
  always @(posedge cs_n) begin
    repeat (8) @(posedge clk);
    #1;
    if (notes.size() > 0) verify(notes.pop_front());
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, well beyond the roughly 73 us the sequence needs.
  initial begin
    #600000;
    fails++;
    tally_and_finish;
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ssf = 1'b0;
    qdo = 1'b0;
    crl = 1'b0;
    m = '{rx_cmd_pkg::CFG_RESET, rx_cmd_pkg::FREQ_RESET,
      rx_cmd_pkg::RX_RESET, rx_cmd_pkg::WAKE_RESET, 16'h0, 8'h0, 8'h0};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    verify(m);
    for (i = 0; i < 4; i++) begin
      rnd = $random(seed);
      send({8'h00, 3'h4, i[1:0], rnd[10:0]}, 16);
    end
    send(24'h00a05f, 16);
    send(24'h00a060, 16);
    send(24'h00af40, 16);
    send(24'h00af3f, 16);
    for (i = 0; i < 16; i++) begin
      rnd = $random(seed);
      send({8'h00, 8'hc0, i[3:0], 3'(rnd[7:0] % 8'h06), rnd[8]}, 16);
      vdi_check;
    end
    rnd = $random(seed);
    send({8'h00, 3'h7, 5'(rnd[4:0] % 5'h1e), rnd[15:8]}, 16);
    send(24'h00c42c, 16);
    send(24'h00c200, 16);
    send(24'h0000a5, 8);
    send(24'h8aaa55, 24);
    send(24'h000047, 7);
    send(24'h009f5d, 16);
    send(24'h00ff00, 16);
    while (notes.size() > 0) @(posedge clk);
    repeat (20) @(posedge clk);
    tally_and_finish;
  end
endmodule

// ===== hdl/rx_cmd_pkg.sv
// Constants shared by the serial command decoder and its shift front end.
// Assumes a 16-bit command word and a 100 MHz system clock.
package rx_cmd_pkg;
  // Command word width and serial bit count.
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] WORD_BITS = 5'h10;
  // Values after power-on.
  localparam logic [15:0] CFG_RESET = 16'h893a;
  localparam logic [15:0] FREQ_RESET = 16'ha680;
  localparam logic [15:0] RX_RESET = 16'hc0c1;
  localparam logic [15:0] WAKE_RESET = 16'he196;
  // Command codes and the software reset word.
  localparam logic [2:0] CODE_CFG = 3'h4;
  localparam logic [3:0] CODE_FREQ = 4'ha;
  localparam logic [7:0] CODE_RX = 8'hc0;
  localparam logic [2:0] CODE_WAKE = 3'h7;
  localparam logic [15:0] SOFT_RESET_WORD = 16'hff00;
  // Legal frequency word range.
  localparam logic [11:0] FREQ_MIN = 12'h060;
  localparam logic [11:0] FREQ_MAX = 12'hf3f;
  // Synthesizer constants per band: C1 and C2 (315, 433, 868, 915).
  localparam logic [1:0] BAND_C1 [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  localparam logic [5:0] BAND_C2 [4] = '{6'h1f, 6'h2b, 6'h2b, 6'h1e};
  // Baseband bandwidth in kHz, index is the 3-bit code; 0 marks reserved.
  localparam logic [8:0] BW_KHZ [8] =
    '{9'h000, 9'h190, 9'h154, 9'h10e, 9'h0c8, 9'h086, 9'h043, 9'h000};
  // LNA attenuation in dB below maximum, index is the 2-bit code.
  localparam logic [4:0] LNA_ATT_DB [4] = '{5'h00, 5'h0e, 5'h06, 5'h14};
  // Lowest threshold magnitude in dBm and its step.
  localparam logic [6:0] RSSI_BASE_DBM = 7'h67;
  localparam logic [6:0] RSSI_STEP_DB = 7'h06;
  // Crystal load: 8.5 pF base, counted in half picofarads.
  localparam logic [5:0] CAP_BASE_HALF_PF = 6'h11;
endpackage

// ===== hdl/rx_config_command_decoder.sv
// Receiver configuration command decoder: holds the command registers.
// Assumes a host drives select, serial clock and data; clk is 100 MHz.
`timescale 1ns/1ps
module rx_config_command_decoder (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Serial command pins from the host.
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  // Detector flags from the analog and recovery blocks.
  input wire logic signal_strength_flag,
  input wire logic quality_detect_out,
  input wire logic clock_recovery_lock,
  // Command words.
  output logic [15:0] rf_config_word,
  output logic [15:0] synth_frequency_word,
  output logic [15:0] receiver_setting_word,
  output logic [15:0] wake_period_word,
  // Decoded configuration fields.
  output logic [1:0] band_sel,
  output logic [8:0] baseband_bw_khz,
  output logic [5:0] crystal_load_half_pf,
  output logic low_batt_detect_on,
  output logic wake_timer_on,
  output logic sleep_crystal_keep,
  output logic clock_output_off,
  output logic clock_tail_enable,
  output logic [1:0] synth_c1,
  output logic [5:0] synth_c2,
  output logic [11:0] synth_frac,
  // Receiver controls.
  output logic valid_data_out,
  output logic [4:0] lna_atten_db,
  output logic [6:0] rssi_thr_neg_dbm,
  output logic receiver_chain_on,
  // Wake-up period fields.
  output logic [4:0] wake_exponent,
  output logic [7:0] wake_mantissa,
  // Words for other decoders, and the reset pulse.
  output logic [15:0] other_cmd_word,
  output logic other_cmd_valid,
  output logic soft_reset_pulse
);
  logic [15:0] word;
  logic word_valid;
  logic [15:0] cfg_next, freq_next, rx_next, wake_next;

  // Serial front end assembles whole words.
  serial_word_shift u_shift (
    .clk(clk),
    .arst_n(arst_n),
    .chip_select_n(chip_select_n),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .word(word),
    .word_valid(word_valid)
  );

  // Command decode from the committed word.
  wire is_reset = word == rx_cmd_pkg::SOFT_RESET_WORD;
  wire is_cfg = word[15:13] == rx_cmd_pkg::CODE_CFG;
  wire is_freq = word[15:12] == rx_cmd_pkg::CODE_FREQ;
  wire is_rx = word[15:8] == rx_cmd_pkg::CODE_RX;
  wire is_wake = (word[15:13] == rx_cmd_pkg::CODE_WAKE) & ~is_reset;
  wire freq_ok = (word[11:0] >= rx_cmd_pkg::FREQ_MIN) &&
                 (word[11:0] <= rx_cmd_pkg::FREQ_MAX);
  wire is_other = ~(is_cfg | is_freq | is_rx | is_wake | is_reset);

  // Next register values; out-of-range frequency keeps the old word.
  assign cfg_next = (word_valid && is_cfg) ? word : rf_config_word;
  assign freq_next = (word_valid && is_freq && freq_ok) ? word
                     : synth_frequency_word;
  assign rx_next = (word_valid && is_rx) ? word : receiver_setting_word;
  assign wake_next = (word_valid && is_wake) ? word : wake_period_word;

  // Decoded fields from the next values (valid source from the current word), so every output is one flop.
  wire [1:0] band_next = cfg_next[12:11];
  wire [2:0] bw_code = cfg_next[3:1];
  wire [1:0] gain_code = rx_next[5:4];
  wire [2:0] thr_code = rx_next[3:1];
  wire [6:0] thr_base = rx_cmd_pkg::RSSI_BASE_DBM -
                        7'(thr_code * rx_cmd_pkg::RSSI_STEP_DB);
  // The gain offset is negative, so the threshold moves further below
  // zero: the magnitude grows by the attenuation (worst case 123 fits).
  wire [6:0] thr_eff = thr_base + {2'h0, rx_cmd_pkg::LNA_ATT_DB[gain_code]};
  wire [1:0] vsrc = receiver_setting_word[7:6];
  wire valid_sel = (vsrc == 2'h0) ? signal_strength_flag
                 : (vsrc == 2'h1) ? quality_detect_out
                 : (vsrc == 2'h2) ? clock_recovery_lock
                 : (signal_strength_flag & quality_detect_out);

  // Command registers; software reset returns them to power-on words.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_config_word <= rx_cmd_pkg::CFG_RESET;
      synth_frequency_word <= rx_cmd_pkg::FREQ_RESET;
      receiver_setting_word <= rx_cmd_pkg::RX_RESET;
      wake_period_word <= rx_cmd_pkg::WAKE_RESET;
    end else if (word_valid && is_reset) begin
      rf_config_word <= rx_cmd_pkg::CFG_RESET;
      synth_frequency_word <= rx_cmd_pkg::FREQ_RESET;
      receiver_setting_word <= rx_cmd_pkg::RX_RESET;
      wake_period_word <= rx_cmd_pkg::WAKE_RESET;
    end else begin
      rf_config_word <= cfg_next;
      synth_frequency_word <= freq_next;
      receiver_setting_word <= rx_next;
      wake_period_word <= wake_next;
    end
  end

  // Decoded configuration outputs, registered on the same edge as the word.
  // A software reset is seen here one cycle late through the words.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      band_sel <= 2'h1;
      baseband_bw_khz <= 9'h086;
      crystal_load_half_pf <= 6'h14;
      low_batt_detect_on <= 1'b0;
      wake_timer_on <= 1'b0;
      sleep_crystal_keep <= 1'b1;
      clock_output_off <= 1'b0;
      synth_c1 <= 2'h1;
      synth_c2 <= 6'h2b;
      synth_frac <= 12'h680;
    end else begin
      band_sel <= band_next;
      baseband_bw_khz <= rx_cmd_pkg::BW_KHZ[bw_code];
      crystal_load_half_pf <= rx_cmd_pkg::CAP_BASE_HALF_PF +
                              {2'h0, cfg_next[7:4]};
      low_batt_detect_on <= cfg_next[10];
      wake_timer_on <= cfg_next[9];
      sleep_crystal_keep <= cfg_next[8];
      clock_output_off <= cfg_next[0];
      synth_c1 <= rx_cmd_pkg::BAND_C1[band_next];
      synth_c2 <= rx_cmd_pkg::BAND_C2[band_next];
      synth_frac <= freq_next[11:0];
    end
  end

  // Receiver, wake and pass-through outputs.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_data_out <= 1'b0;
      lna_atten_db <= 5'h00;
      rssi_thr_neg_dbm <= 7'h67;
      receiver_chain_on <= 1'b1;
      clock_tail_enable <= 1'b0;
      wake_exponent <= 5'h01;
      wake_mantissa <= 8'h96;
      other_cmd_word <= 16'h0000;
      other_cmd_valid <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      valid_data_out <= valid_sel;
      lna_atten_db <= rx_cmd_pkg::LNA_ATT_DB[gain_code];
      rssi_thr_neg_dbm <= thr_eff;
      receiver_chain_on <= rx_next[0];
      // The enable bit never asks for trailing clocks on the output.
      clock_tail_enable <= 1'b0;
      wake_exponent <= wake_next[12:8];
      wake_mantissa <= wake_next[7:0];
      other_cmd_valid <= word_valid & is_other;
      if (word_valid && is_other) begin
        other_cmd_word <= word;
      end
      soft_reset_pulse <= word_valid & is_reset;
    end
  end

  AST_FREQ_RANGE_KEEP: assert property (@(posedge clk) disable iff (!arst_n)
    (word_valid && is_freq && !freq_ok) |=>
      $stable(synth_frequency_word))
    else $error("out of range frequency was stored");
  AST_FREQ_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
    (word_valid && is_freq && freq_ok) |=>
      synth_frequency_word == $past(word))
    else $error("frequency command not stored");
  AST_CFG_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
    (word_valid && is_cfg) |=> ##1 band_sel == rf_config_word[12:11] &&
      wake_timer_on == rf_config_word[9])
    else $error("configuration fields not decoded");
  AST_RX_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
    (word_valid && is_rx) |=> receiver_setting_word == $past(word) ##1
      receiver_chain_on == receiver_setting_word[0])
    else $error("receiver command not applied");
  AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    (word_valid && is_reset) |=> rf_config_word == 16'h893a &&
      wake_period_word == 16'he196 && soft_reset_pulse)
    else $error("software reset not performed");
  AST_WAKE_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
    (word_valid && is_wake) |=> ##1 wake_exponent == $past(word[12:8], 2) &&
      wake_mantissa == $past(word[7:0], 2))
    else $error("wake fields not loaded");
  AST_OTHER_UNCHANGED: assert property (@(posedge clk) disable iff (!arst_n)
    (word_valid && is_other) |=> $stable(rf_config_word) &&
      $stable(receiver_setting_word) && other_cmd_valid)
    else $error("unknown command changed a register");
  AST_VALID_AND: assert property (@(posedge clk) disable iff (!arst_n)
    (vsrc == 2'h3) |=> valid_data_out ==
      ($past(signal_strength_flag) & $past(quality_detect_out)))
    else $error("valid output not the AND of flags");
  AST_NO_TAIL: assert property (@(posedge clk) disable iff (!arst_n)
    !clock_tail_enable)
    else $error("clock tail requested");
endmodule

// ===== hdl/serial_word_shift.sv
// Serial shift front end: synchronises the serial pins and assembles words.
// Assumes select, serial clock and data arrive asynchronously to clk.
`timescale 1ns/1ps
module serial_word_shift (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Serial pins.
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  // Assembled word, pulsed when select rises after exactly 16 bits.
  output logic [15:0] word,
  output logic word_valid
);
  logic [2:0] sync1_reg, sync2_reg;
  logic sck_prev_reg, sel_prev_reg;
  logic [15:0] shift_reg;
  logic [4:0] cnt_reg;
  wire sel_n = sync2_reg[0];
  wire sck_rise = sync2_reg[1] & ~sck_prev_reg;
  wire sel_rise = sel_n & ~sel_prev_reg;
  wire take_bit = sck_rise & ~sel_n;
  wire full = (cnt_reg == rx_cmd_pkg::WORD_BITS);

  // Two flip-flops on every pin before any logic looks at them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {serial_data, serial_clk, chip_select_n};
      sync2_reg <= sync1_reg;
    end
  end

  // Shift MSB first on a rising serial clock while selected; select high
  // clears the count so the next frame starts fresh.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
      shift_reg <= 16'h0000;
      cnt_reg <= 5'h00;
      word <= 16'h0000;
      word_valid <= 1'b0;
    end else begin
      sck_prev_reg <= sync2_reg[1];
      sel_prev_reg <= sel_n;
      word_valid <= sel_rise & full;
      if (sel_rise) begin
        word <= shift_reg;
      end
      if (sel_n) begin
        cnt_reg <= 5'h00;
      end else if (take_bit) begin
        shift_reg <= {shift_reg[14:0], sync2_reg[2]};
        // Longer frames run the count on to a saturating 31, never back to 16, and are not committed.
        if (cnt_reg != 5'h1f) begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end

  AST_COMMIT_ONLY_FULL: assert property (@(posedge clk) disable iff (!arst_n)
    word_valid |-> $past(full) && $past(sel_rise))
    else $error("word committed without sixteen bits");
  AST_SELECT_CLEARS: assert property (@(posedge clk) disable iff (!arst_n)
    sel_n |=> cnt_reg == 5'h00)
    else $error("bit count not cleared by select high");
endmodule
